// ==== design/dpmb_ctrl.sv ====
// host controller driving one port of the dual-port memory
`timescale 1ns/1ns
module dpmb_ctrl
    import dpmb_pkg::*;
#(
    parameter logic [ADDR_W-1:0] OWN_MAILBOX = MAILBOX_LEFT,
    parameter int                CASCADE     = 1
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // software port
    input  wire logic [3:0]              sw_addr,
    input  wire logic [31:0]             sw_wdata,
    input  wire logic                    sw_wr,
    input  wire logic                    sw_rd,
    output logic      [31:0]             sw_rdata,
    // device port pins
    output dpmb_ctl_t                    pin_ctl,
    output logic      [DATA_W-1:0]       pin_dq_o,
    output logic                         pin_dq_oe,
    input  wire logic [DATA_W-1:0]       pin_dq_i,
    input  wire logic [CASCADE-1:0]      conflict_in,
    output logic      [CASCADE-1:0]      conflict_o,
    output logic      [CASCADE-1:0]      conflict_oe,
    input  wire logic                    mailbox_irq_n,
    output logic                         irq_pending
);
    dpmb_state_t state;
    logic [CNT_W-1:0]       cnt;
    logic [ADDR_W-1:0]      req_addr;
    logic [DATA_W-1:0]      req_wdata;
    logic [DATA_W-1:0]      rdata;
    logic                   op_write;
    logic                   op_token;
    logic                   stall_en;
    logic                   slave_role;
    logic                   inhibit;
    logic                   saw_conflict;
    logic [CASCADE-1:0]     conf_sync;
    logic                   irq_sync;
    logic                   conflict_n;
    logic                   hit_ctrl;
    logic                   irq_armed;

    dpmb_sync #(.W(CASCADE + 1)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    ({conflict_in, mailbox_irq_n}),
        .dout   ({conf_sync, irq_sync})
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction : cyc

    // cascaded devices: any low member means the array is busy
    // in slave role the pin carries our own inhibit drive, so it is no indication;
    // reading it back would stall forever while inhibiting
    assign conflict_n = slave_role || &conf_sync;
    // irq pin powers up unknown: reported only once own mailbox was read
    assign irq_pending = irq_armed && !irq_sync;

    // in slave role the host drives the inhibit input; high unless software inhibits
    assign conflict_oe = {CASCADE{slave_role}};
    assign conflict_o  = {CASCADE{~inhibit}};

    assign hit_ctrl = sw_wr && sw_addr == REG_CTRL;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slave_role <= 1'b0;
            inhibit    <= 1'b0;
            stall_en   <= 1'b0;
        end else if (hit_ctrl) begin
            slave_role <= sw_wdata[BIT_SLAVE_ROLE];
            inhibit    <= sw_wdata[BIT_INHIBIT];
            stall_en   <= sw_wdata[BIT_STALL];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_addr  <= '0;
            req_wdata <= '0;
            op_write  <= 1'b0;
            op_token  <= 1'b0;
        end else if (state == S_IDLE) begin
            if (sw_wr && sw_addr == REG_ADDR)
                req_addr <= sw_wdata[ADDR_W-1:0];
            if (sw_wr && sw_addr == REG_WDATA)
                req_wdata <= sw_wdata[DATA_W-1:0];
            if (hit_ctrl && sw_wdata[BIT_GO]) begin
                op_write <= sw_wdata[BIT_WRITE];
                op_token <= sw_wdata[BIT_TOKEN];
            end
        end
    end

    // access sequencer: setup, strobe, hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (hit_ctrl && sw_wdata[BIT_GO]) begin
                        state <= S_SETUP;
                        cnt   <= cyc(SETUP_CYC);
                    end
                end
                S_SETUP: begin
                    if (cnt > cyc(1))
                        cnt <= cnt - cyc(1);
                    else begin
                        state <= S_STROBE;
                        cnt   <= cyc(STROBE_CYC);
                    end
                end
                S_STROBE: begin
                    // optional stall: hold the strobe until the other side is done
                    if (stall_en && !conflict_n && !op_token) begin
                        cnt <= cyc(STROBE_CYC);
                    end else if (cnt > cyc(1))
                        cnt <= cnt - cyc(1);
                    else begin
                        state <= S_HOLD;
                        cnt   <= cyc(HOLD_CYC);
                    end
                end
                S_HOLD: begin
                    if (cnt > cyc(1))
                        cnt <= cnt - cyc(1);
                    else
                        state <= S_DONE;
                end
                S_DONE:  state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // pin drive: select and read output enable during setup/strobe/hold, write only in strobe
    always_comb begin
        pin_ctl.addr                 = req_addr;
        pin_ctl.mem_sel_n            = 1'b1;
        pin_ctl.token_space_select_n = 1'b1;
        pin_ctl.rw_n                 = 1'b1;
        pin_ctl.out_en_n             = 1'b1;
        if (state == S_SETUP || state == S_STROBE || state == S_HOLD) begin
            pin_ctl.mem_sel_n            = op_token;
            pin_ctl.token_space_select_n = ~op_token;
            pin_ctl.rw_n                 = !(op_write && state == S_STROBE);
            pin_ctl.out_en_n             = op_write;
        end
    end

    // token writes use bit zero only; the rest are kept low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_dq_o  <= '0;
            pin_dq_oe <= 1'b0;
        end else begin
            pin_dq_oe <= op_write && (state == S_SETUP || state == S_STROBE);
            pin_dq_o  <= op_token ? {{(DATA_W-1){1'b0}}, req_wdata[0]} : req_wdata;
        end
    end

    // read data captured at end of strobe, whole word for token reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rdata <= '0;
        else if (state == S_STROBE && cnt == cyc(1) && !op_write)
            rdata <= pin_dq_i;
    end

    // a master conflict during a memory strobe is recorded; without stall a write is then dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            saw_conflict <= 1'b0;
        else if (state == S_SETUP && cnt == cyc(SETUP_CYC))
            saw_conflict <= 1'b0;
        else if (state == S_STROBE && !op_token && !conflict_n)
            saw_conflict <= 1'b1;
    end

    // a completed read of own mailbox is the clearing access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            irq_armed <= 1'b0;
        else if (state == S_DONE && !op_token && !op_write && req_addr == OWN_MAILBOX)
            irq_armed <= 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            sw_rdata <= '0;
        else if (sw_rd) begin
            case (sw_addr)
                REG_STATUS: sw_rdata <= {28'h0000000, saw_conflict, irq_pending,
                                         ~conflict_n, state != S_IDLE};
                REG_ADDR:   sw_rdata <= {20'h00000, req_addr};
                REG_WDATA:  sw_rdata <= {14'h0000, req_wdata};
                REG_RDATA:  sw_rdata <= {14'h0000, rdata};
                default:    sw_rdata <= 32'h00000000;
            endcase
        end else
            sw_rdata <= 32'h00000000;
    end

    property p_token_select;
        @(posedge clk) disable iff (!arst_n)
        (state != S_IDLE && state != S_DONE && op_token)
            |-> (pin_ctl.mem_sel_n && !pin_ctl.token_space_select_n);
    endproperty
    a_token_select: assert property (p_token_select)
        else $error("token access without proper selects");

    property p_token_bit;
        @(posedge clk) disable iff (!arst_n)
        (pin_dq_oe && op_token) |-> (pin_dq_o[DATA_W-1:1] == '0);
    endproperty
    a_token_bit: assert property (p_token_bit)
        else $error("token write drives upper data bits");

    property p_slave_drive;
        @(posedge clk) disable iff (!arst_n)
        hit_ctrl |=> (conflict_oe == {CASCADE{$past(sw_wdata[BIT_SLAVE_ROLE])}})
            && (conflict_o == {CASCADE{!$past(sw_wdata[BIT_INHIBIT])}});
    endproperty
    a_slave_drive: assert property (p_slave_drive)
        else $error("slave conflict input not driven");

    property p_stall;
        @(posedge clk) disable iff (!arst_n)
        (state == S_STROBE && stall_en && !conflict_n && !op_token) |=> state == S_STROBE;
    endproperty
    a_stall: assert property (p_stall)
        else $error("strobe ended during conflict stall");

    property p_sequence;
        @(posedge clk) disable iff (!arst_n)
        (state == S_IDLE && hit_ctrl && sw_wdata[BIT_GO]) |=> state == S_SETUP ##1
            (state == S_SETUP || state == S_STROBE);
    endproperty
    a_sequence: assert property (p_sequence)
        else $error("access did not start");

    property p_irq_arm;
        @(posedge clk) disable iff (!arst_n)
        (state == S_DONE && !op_token && !op_write && req_addr == OWN_MAILBOX)
            |=> irq_armed;
    endproperty
    a_irq_arm: assert property (p_irq_arm)
        else $error("own mailbox read did not arm irq");
endmodule : dpmb_ctrl

// ==== design/dpmb_sync.sv ====
// two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dpmb_sync
    import dpmb_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // signals
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage;

    // reset value high: conflict and irq pins idle high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage <= '1;
            dout  <= '1;
        end else begin
            stage <= din;
            dout  <= stage;
        end
    end
endmodule : dpmb_sync

// ==== shared/dpmb_pkg.sv ====
// package for the dual-port mailbox and semaphore controller
package dpmb_pkg;
    localparam int ADDR_W        = 12;
    localparam int DATA_W        = 18;
    localparam int TOKEN_IDX_W   = 3;
    localparam int TOKEN_COUNT   = 8;
    localparam logic [11:0] MAILBOX_LEFT  = 12'hffe;
    localparam logic [11:0] MAILBOX_RIGHT = 12'hfff;
    // pin timing in ns and derived cycles at 50 MHz
    localparam int CLK_NS        = 20;
    localparam int SETUP_NS      = 20;
    localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_NS     = 40;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_NS       = 20;
    localparam int HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 4;
    // software registers (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_WDATA  = 4'h8;
    localparam logic [3:0] REG_RDATA  = 4'hc;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam int BIT_GO        = 0;
    localparam int BIT_WRITE     = 1;
    localparam int BIT_TOKEN     = 2;
    localparam int BIT_STALL     = 3;
    localparam int BIT_SLAVE_ROLE = 4;
    localparam int BIT_INHIBIT   = 5;
    localparam int ST_BUSY       = 0;
    localparam int ST_CONFLICT   = 1;
    localparam int ST_IRQ        = 2;
    localparam int ST_SAW_CONF   = 3;

    typedef struct packed {
        logic              mem_sel_n;
        logic              token_space_select_n;
        logic              rw_n;
        logic              out_en_n;
        logic [ADDR_W-1:0] addr;
    } dpmb_ctl_t;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_DONE} dpmb_state_t;
endpackage : dpmb_pkg

// ==== verif/dpmb_ctrl_tb.sv ====
// bench: two port controllers facing one device model
`timescale 1ns/1ns
module dpmb_ctrl_tb
    import dpmb_pkg::*;
;
    localparam logic [31:0] WR = 32'h1 << BIT_WRITE;
    localparam logic [31:0] TK = 32'h1 << BIT_TOKEN;
    // token steps: port, value, left read, right read
    localparam logic [31:0] SEQ = 32'h1962d7af;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [3:0]        sa [2];
    logic [31:0]       swd [2];
    logic [31:0]       rdat [2];
    logic [1:0]        wr, rd, oe, busy_n, irq_n, cf_o, cf_oe, irqp;
    dpmb_ctl_t         ctl [2];
    logic [DATA_W-1:0] dqo [2];
    logic [DATA_W-1:0] dqi [2];
    logic [DATA_W-1:0] dqd [2];
    logic [31:0]       v;
    logic [3:0]        e;
    int                err_total = 0;
    int                tests_run = 0;
    int                cyc = 0;
    always #10 clk = ~clk;
    for (genvar p = 0; p < 2; p++) begin : g_port
        dpmb_ctrl #(.OWN_MAILBOX(p ? MAILBOX_RIGHT : MAILBOX_LEFT)) dpmb_ctrl_inst (
            .clk(clk), .arst_n(arst_n), .sw_addr(sa[p]), .sw_wdata(swd[p]),
            .sw_wr(wr[p]), .sw_rd(rd[p]), .sw_rdata(rdat[p]), .pin_ctl(ctl[p]),
            .pin_dq_o(dqo[p]), .pin_dq_oe(oe[p]), .pin_dq_i(dqi[p]),
            .conflict_in(busy_n[p]), .conflict_o(cf_o[p]), .conflict_oe(cf_oe[p]),
            .mailbox_irq_n(irq_n[p]), .irq_pending(irqp[p]));
        // undriven data lines read unknown, so a late enable corrupts the array
        assign dqd[p] = oe[p] ? dqo[p] : {DATA_W{1'bx}};
    end
    dpmb_dev_model dpmb_dev_model_inst (.clk(clk), .c(ctl), .d(dqd), .q(dqi),
        .busy_n(busy_n), .irq_n(irq_n));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input int p, input logic [3:0] a, input logic [31:0] dat);
        @(posedge clk);
        sa[p] <= a;
        swd[p] <= dat;
        wr[p] <= 1'b1;
        @(posedge clk);
        wr[p] <= 1'b0;
    endtask : wreg
    task automatic rreg(input int p, input logic [3:0] a);
        @(posedge clk);
        sa[p] <= a;
        rd[p] <= 1'b1;
        @(posedge clk);
        rd[p] <= 1'b0;
        #1 v = rdat[p];
    endtask : rreg
    // bounded poll; leaves the final status in v
    task automatic idle(input int p);
        for (int n = 0; n < 20; n++) begin
            rreg(p, REG_STATUS);
            if (v[ST_BUSY] === 1'b0)
                return;
        end
        chk(v, 32'h0);
    endtask : idle
    task automatic acc(input int p, input logic [31:0] cw, input logic [11:0] a,
                       input logic [31:0] dat);
        wreg(p, REG_ADDR, 32'(a));
        wreg(p, REG_WDATA, dat);
        wreg(p, REG_CTRL, cw | 32'h1);
        idle(p);
        rreg(p, REG_RDATA);
    endtask : acc
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            $display("BAD t=%0t timeout", $time);
            print_verdict();
        end
    end
    initial begin
        wr = 2'b00;
        rd = 2'b00;
        sa = '{4'h0, 4'h0};
        swd = '{32'h0, 32'h0};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        acc(0, 0, MAILBOX_LEFT, 0);
        acc(1, 0, MAILBOX_RIGHT, 0);
        chk(32'(irqp), 32'h0);
        acc(0, WR, 12'h123, 32'h2a5a5);
        acc(1, 0, 12'h123, 0);
        chk(v, 32'h2a5a5);
        acc(1, WR, MAILBOX_LEFT, 32'h3c3c3);
        chk(32'(irqp), 32'h1);
        acc(0, 0, MAILBOX_LEFT, 0);
        chk(v, 32'h3c3c3);
        chk(32'(irqp), 32'h0);
        acc(0, WR, MAILBOX_RIGHT, 32'h1);
        chk(32'(irqp), 32'h2);
        acc(1, 0, MAILBOX_RIGHT, 0);
        chk(32'(irqp), 32'h0);
        $display("test mailbox done");
        for (int k = 0; k < 8; k++) begin
            e = SEQ[31-4*k -: 4];
            acc(int'(e[3]), TK | WR, 12'h005, 32'(e[2]));
            acc(0, TK, 12'h005, 0);
            chk(v, {14'h0, {DATA_W{e[1]}}});
            acc(1, TK, 12'h005, 0);
            chk(v, {14'h0, {DATA_W{e[0]}}});
        end
        $display("test token done");
        // second pass: right stalls on its conflict and writes once left is done
        for (int k = 0; k < 2; k++) begin
            wreg(0, REG_ADDR, 32'h100);
            wreg(0, REG_WDATA, 32'h111);
            wreg(1, REG_ADDR, 32'h100);
            wreg(1, REG_WDATA, 32'h222);
            // left starts one cycle ahead, so right settles later
            @(posedge clk);
            sa[0] <= REG_CTRL;
            swd[0] <= WR | 32'h1;
            wr[0] <= 1'b1;
            @(posedge clk);
            wr[0] <= 1'b0;
            sa[1] <= REG_CTRL;
            swd[1] <= WR | 32'h1 | 32'(k) << BIT_STALL;
            wr[1] <= 1'b1;
            @(posedge clk);
            wr[1] <= 1'b0;
            idle(0);
            chk(32'(v[ST_SAW_CONF]), 32'h0);
            idle(1);
            chk(32'(v[ST_SAW_CONF]), 32'h1);
            acc(0, 0, 12'h100, 0);
            chk(v, k ? 32'h222 : 32'h111);
        end
        $display("test conflict done");
        wreg(0, REG_CTRL, 32'h1 << BIT_SLAVE_ROLE | 32'h1 << BIT_INHIBIT);
        @(posedge clk);
        #1 chk(32'({cf_oe[0], cf_o[0]}), 32'h2);
        wreg(0, REG_CTRL, 32'h1 << BIT_SLAVE_ROLE);
        #1 chk(32'({cf_oe[0], cf_o[0]}), 32'h3);
        wreg(0, REG_CTRL, 0);
        #1 chk(32'({cf_oe[0], cf_o[0]}), 32'h1);
        $display("test slave done");
        print_verdict();
    end
endmodule : dpmb_ctrl_tb

// ==== verif/dpmb_dev_model.sv ====
// behavioural model of the dual-port memory: array, tokens, mailboxes, conflict
`timescale 1ns/1ns
module dpmb_dev_model
    import dpmb_pkg::*;
(
    // sampling clock
    input  wire logic              clk,
    // port pins, index 0 left, 1 right
    input  wire dpmb_ctl_t         c [2],
    input  wire logic [DATA_W-1:0] d [2],
    output logic      [DATA_W-1:0] q [2],
    output logic      [1:0]        busy_n,
    output logic      [1:0]        irq_n
);
    logic [DATA_W-1:0] mem [4096];
    logic [DATA_W-1:0] lat [2];
    logic [DATA_W-1:0] last [2];
    logic [1:0]        own [TOKEN_COUNT];
    logic [1:0]        req [TOKEN_COUNT];
    logic [1:0]        sel, ts, act, was, win, win_c;
    logic              match;
    // flags start set: no kinder than power-up
    initial begin
        irq_n = 2'b00;
        win = 2'b00;
        act = 2'b00;
        last = '{18'h0, 18'h0};
        for (int i = 0; i < TOKEN_COUNT; i++) begin
            own[i] = 2'd0;
            req[i] = 2'b00;
        end
    end
    // master role only; slave-role inputs are not modelled
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            sel[p] = !c[p].mem_sel_n;
            ts[p] = !c[p].token_space_select_n && c[p].mem_sel_n;
            q[p] = ~last[p];
            if ((sel[p] || ts[p]) && !c[p].out_en_n && c[p].rw_n)
                q[p] = ts[p] ? lat[p] : mem[c[p].addr];
        end
        match = &sel && c[0].addr == c[1].addr;
        win_c = win != 2'b00 ? win : !match ? 2'b00 : was == 2'b10 ? 2'b01 : 2'b10;
        busy_n = match ? ~win_c : 2'b11;
    end
    always @(posedge clk) begin
        win <= match ? win_c : 2'b00;
        was <= sel;
        for (int p = 0; p < 2; p++) begin
            automatic int         o = 1 - p;
            automatic int         i = int'(c[p].addr[2:0]);
            automatic logic [1:0] me = 2'(p + 1);
            last[p] <= q[p];
            act[p] <= ts[p] && !c[p].out_en_n;
            if (ts[p] && !c[p].out_en_n && !act[p])
                lat[p] <= {DATA_W{own[i] != me}};
            if (sel[p] && !c[p].rw_n && busy_n[p])
                mem[c[p].addr] <= d[p];
            if (sel[p] && !c[p].rw_n && c[p].addr == (p ? MAILBOX_LEFT : MAILBOX_RIGHT))
                irq_n[o] <= 1'b0;
            if (sel[p] && !c[p].out_en_n && c[p].addr == (p ? MAILBOX_RIGHT : MAILBOX_LEFT))
                irq_n[p] <= 1'b1;
            if (ts[p] && !c[p].rw_n && !d[p][0]) begin
                if (own[i] == 2'd0)
                    own[i] <= me;
                else if (own[i] != me)
                    req[i][p] <= 1'b1;
            end else if (ts[p] && !c[p].rw_n) begin
                if (own[i] == me) begin
                    own[i] <= req[i][o] ? 2'(o + 1) : 2'd0;
                    req[i][o] <= 1'b0;
                end else
                    req[i][p] <= 1'b0;
            end
        end
    end
endmodule : dpmb_dev_model
